// file: hw/prpo_cell.sv
`timescale 1ns/1ns
// one macrocell flip-flop with clear, preload and async reset/preset terms
module prpo_cell
  import prpo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic preload,
  input wire logic pin_val,
  input wire logic d,
  input wire logic ar,
  input wire logic ap,
  output logic q
);
  typedef struct packed {
    logic q;
  } prpo_cell_s;
  prpo_cell_s st_reg;
  prpo_cell_s st_next;

  // async terms beat a preload, so a bad preload is overwritten
  always_comb
  begin
    st_next = st_reg;
    if (clear)
      st_next.q = 1'b0;
    else if (ar)
      st_next.q = 1'b0;
    else if (ap)
      st_next.q = 1'b1;
    else if (preload)
      st_next.q = pin_val;
    else
      st_next.q = d;
  end

  always_ff @(posedge sys_clk)
  begin
    st_reg <= st_next;
  end

  assign q = st_reg.q;
endmodule : prpo_cell

// file: hw/prpo_pkg.sv
package prpo_pkg;
  localparam int PRPO_NREG = 8;
  localparam int PRPO_CLK_MHZ = 100;
  // power-up reset time, microseconds, longest allowed
  localparam int PRPO_T_PR_US = 10;
  localparam int PRPO_PR_CYCLES = (PRPO_T_PR_US * PRPO_CLK_MHZ) - 1;
  localparam int PRPO_PR_W = 10;
  localparam logic [PRPO_PR_W-1:0] PRPO_PR_LAST = PRPO_PR_W'(PRPO_PR_CYCLES);
  localparam logic [PRPO_NREG-1:0] PRPO_REG_RESET = 8'h00;

  typedef enum logic [1:0] {PRPO_NORMAL, PRPO_PRELOAD, PRPO_OBSERVE, PRPO_SPARE} prpo_mode_e;

  // per-macrocell configuration straps
  typedef struct packed {
    logic [PRPO_NREG-1:0] polarity;   // 1 inverts register onto the pin
    logic [PRPO_NREG-1:0] comb;       // 1 output is combinatorial
    logic [PRPO_NREG-1:0] oe;         // programmed output enable
  } prpo_cfg_s;

  typedef struct packed {
    logic [PRPO_NREG-1:0] dout;
    logic [PRPO_NREG-1:0] oe;
  } prpo_pin_s;
endpackage : prpo_pkg

// file: hw/prpo_top.sv
`timescale 1ns/1ns
// Overview of operation
// - power-up clears every flip-flop low
// - internal power-up reset finishes within 10 us
// - pin level follows programmed output polarity
// - preload loads all flip-flops from pins
// - observe forces output buffers on
// - async reset or preset overrides preload
// - observe forces combinatorial outputs registered
// - forced outputs get product terms zeroed
// - combinatorial outputs recover after test ends
module prpo_top
  import prpo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire prpo_pkg::prpo_mode_e test_mode,
  input wire prpo_pkg::prpo_cfg_s cfg,
  input wire logic [prpo_pkg::PRPO_NREG-1:0] pin_in,
  input wire logic [prpo_pkg::PRPO_NREG-1:0] d_in,
  input wire logic [prpo_pkg::PRPO_NREG-1:0] comb_in,
  input wire logic [prpo_pkg::PRPO_NREG-1:0] ar_term,
  input wire logic [prpo_pkg::PRPO_NREG-1:0] ap_term,
  output prpo_pkg::prpo_pin_s pin_out,
  output logic por_busy,
  output logic [prpo_pkg::PRPO_NREG-1:0] reg_q
);
  import prpo_pkg::*;

  typedef struct packed {
    logic [PRPO_PR_W-1:0] pr_cnt;
    logic por_busy;
    logic [PRPO_NREG-1:0] pin_s1;
    logic [PRPO_NREG-1:0] pin_s2;
    prpo_mode_e mode_s1;
    prpo_mode_e mode_s2;
    prpo_pin_s pins;
  } prpo_top_s;
  // initial value models power-on; reset re-runs the sequence
  prpo_top_s st_reg = '{pr_cnt: '0, por_busy: 1'b1, pin_s1: '0, pin_s2: '0,
                        mode_s1: PRPO_NORMAL, mode_s2: PRPO_NORMAL, pins: '0};
  prpo_top_s st_next;

  logic preload_now;
  logic observe_now;
  logic [PRPO_NREG-1:0] q;
  logic [PRPO_NREG-1:0] pt_gate;

  // spare select code acts as normal mode
  assign preload_now = !st_reg.por_busy && st_reg.mode_s2 == PRPO_PRELOAD;
  assign observe_now = !st_reg.por_busy && st_reg.mode_s2 == PRPO_OBSERVE;
  // product terms zeroed on combinatorial outputs during any test mode
  assign pt_gate = (preload_now || observe_now) ? ~cfg.comb : {PRPO_NREG{1'b1}};

  // flip-flops, buried ones included; async terms win over preload
  genvar gi;
  generate
    for (gi = 0; gi < PRPO_NREG; gi++)
    begin : g_cell
      prpo_cell u_cell (
        .sys_clk(sys_clk),
        .clear(st_reg.por_busy),
        .preload(preload_now),
        .pin_val(st_reg.pin_s2[gi]),
        .d(d_in[gi] & pt_gate[gi]),
        .ar(ar_term[gi] & !st_reg.por_busy),
        .ap(ap_term[gi] & !st_reg.por_busy),
        .q(q[gi])
      );
    end
  endgenerate

  // power-up sequencing and pin drive
  always_comb
  begin
    st_next = st_reg;
    st_next.pin_s1 = pin_in;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.mode_s1 = test_mode;
    st_next.mode_s2 = st_reg.mode_s1;
    if (st_reg.por_busy)
    begin
      if (st_reg.pr_cnt == PRPO_PR_LAST)
        st_next.por_busy = 1'b0;
      else
        st_next.pr_cnt = st_reg.pr_cnt + PRPO_PR_W'(1);
    end
    for (int i = 0; i < PRPO_NREG; i++)
    begin
      if (observe_now)
      begin
        // combinatorial outputs show the register instead
        st_next.pins.dout[i] = q[i] ^ cfg.polarity[i];
        st_next.pins.oe[i] = 1'b1;
      end
      else if (preload_now)
      begin
        // pins are inputs while the tester drives them
        st_next.pins.dout[i] = 1'b0;
        st_next.pins.oe[i] = 1'b0;
      end
      else
      begin
        // combinatorial path recomputed from live inputs after test
        st_next.pins.dout[i] = (cfg.comb[i] ? comb_in[i] : q[i]) ^ cfg.polarity[i];
        st_next.pins.oe[i] = cfg.oe[i];
      end
    end
    if (reset)
    begin
      st_next.pr_cnt = '0;
      st_next.por_busy = 1'b1;
    end
  end

  // only the clocked process writes the state; power-on value sits on the declaration
  always_ff @(posedge sys_clk)
  begin
    st_reg <= st_next;
  end

  assign pin_out = st_reg.pins;
  assign por_busy = st_reg.por_busy;
  assign reg_q = q;

  AST_POR_CLEARS: assert property (@(posedge sys_clk)
    por_busy |=> q == PRPO_REG_RESET)
    else $error("flip-flops not cleared by power-up reset");

  // measured from reset release, so the power-on value cannot open a false window
  AST_POR_BOUNDED: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> ##[1:1000] !por_busy)
    else $error("power-up reset longer than 10 us");

  sequence s_preload_taken;
    preload_now && ar_term == '0 && ap_term == '0;
  endsequence
  AST_PRELOAD_LOADS: assert property (@(posedge sys_clk) disable iff (reset)
    s_preload_taken |=> q == $past(st_reg.pin_s2))
    else $error("preload value not loaded");

  AST_OBSERVE_OE: assert property (@(posedge sys_clk) disable iff (reset)
    observe_now |=> pin_out.oe == {PRPO_NREG{1'b1}})
    else $error("observe did not force output enables");

  AST_ASYNC_WINS: assert property (@(posedge sys_clk) disable iff (reset)
    (preload_now && ar_term[0] && !por_busy) |=> !q[0])
    else $error("reset term did not override preload");

  AST_OBS_REGISTERED: assert property (@(posedge sys_clk) disable iff (reset)
    observe_now |=> pin_out.dout == ($past(q) ^ cfg.polarity))
    else $error("observe pin does not show register");

  AST_PT_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    (observe_now && cfg.comb[0] && !ar_term[0] && !ap_term[0]) |=> !q[0])
    else $error("product terms not zeroed in test mode");

  AST_COMB_RESTORE: assert property (@(posedge sys_clk) disable iff (reset)
    (!preload_now && !observe_now && cfg.comb[0] && !por_busy)
      |=> pin_out.dout[0] == ($past(comb_in[0]) ^ $past(cfg.polarity[0])))
    else $error("combinatorial output not restored");

  AST_PIN_POLARITY: assert property (@(posedge sys_clk) disable iff (reset)
    (st_reg.mode_s2 == PRPO_NORMAL && !por_busy && !cfg.comb[1])
      |=> pin_out.dout[1] == ($past(q[1]) ^ $past(cfg.polarity[1])))
    else $error("output polarity not applied");
endmodule : prpo_top

// file: testbench/prpo_tester.sv
`timescale 1ns/1ns
// tester standing at the pins; holds normal mode and toggles the pins until power-up clear is over
module prpo_tester
  import prpo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic por_busy,
  input wire prpo_pkg::prpo_mode_e want_mode,
  input wire logic [prpo_pkg::PRPO_NREG-1:0] want_pins,
  output prpo_pkg::prpo_mode_e test_mode = PRPO_NORMAL,
  output logic [prpo_pkg::PRPO_NREG-1:0] pin_in = 8'h00
);
  // no mode request until busy drops; pin data toggles meanwhile
  always @(posedge sys_clk)
  begin
    test_mode <= por_busy ? PRPO_NORMAL : want_mode;
    pin_in <= por_busy ? ~pin_in : want_pins; // toggling, never stale
  end
endmodule : prpo_tester

// file: testbench/prpo_top_tb_top.sv
`timescale 1ns/1ns
module prpo_top_tb_top;
  import prpo_pkg::*;
  logic sys_clk = 0, reset = 1, look = 0, por_busy;
  prpo_mode_e want_mode = PRPO_NORMAL, test_mode;
  prpo_cfg_s cfg;
  logic [7:0] want_pins = 8'h00, pin_in, d_in = 8'h00, comb_in = 8'h00, reg_q;
  logic [7:0] ar_term = 8'h00, ap_term = 8'h00, v, a, p, r;
  prpo_pin_s pin_out;
  logic [24:0] exp_q[$], msk_q[$], e, m;
  int errors = 0, cmp_count = 0, i, it, seed = 47975;
  prpo_top u_prpo_top (.sys_clk(sys_clk), .reset(reset), .test_mode(test_mode), .cfg(cfg),
    .pin_in(pin_in), .d_in(d_in), .comb_in(comb_in), .ar_term(ar_term), .ap_term(ap_term),
    .pin_out(pin_out), .por_busy(por_busy), .reg_q(reg_q));
  prpo_tester u_prpo_tester (.sys_clk(sys_clk), .por_busy(por_busy), .want_mode(want_mode),
    .want_pins(want_pins), .test_mode(test_mode), .pin_in(pin_in));
  always #5 sys_clk = ~sys_clk;
  // expected {busy, flops, pin data, pin enable} under a mask
  task note(input logic [24:0] ev, input logic [24:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
    @(posedge sys_clk);
  endtask : note
  // checker samples mid-cycle so the edge's updates have landed
  always @(negedge sys_clk)
  begin
    if (look)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      cmp_count++;
      if ((({por_busy, reg_q, pin_out}) & m) !== e)
        $display("ERROR %0t exp %h got %h", $time, e, {por_busy, reg_q, pin_out} & m);
    end
    if (look && ((({por_busy, reg_q, pin_out}) & m) !== e)) errors++;
  end
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // hang guard, well past the roughly 1100 cycles the tests need
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
  initial
  begin
    cfg = prpo_cfg_s'(24'($random(seed)));
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    note({1'b1, 24'h0}, {1'b1, 8'hff, 16'h0});
    i = 0;
    while (por_busy !== 1'b0 && i < 1010)
    begin
      @(posedge sys_clk);
      i++;
    end
    note(25'h0, {1'b1, 24'h0});
    note({9'h0, cfg.polarity & ~cfg.comb, cfg.oe}, {9'h0ff, ~cfg.comb, 8'hff});
    for (it = 0; it < 4; it++)
    begin
      v = 8'($random(seed));
      a = it[0] ? 8'($random(seed)) : 8'h00; // even passes keep async terms quiet
      p = it[0] ? 8'($random(seed)) & ~a : 8'h00;
      r = (v & ~a) | p;
      comb_in <= 8'($random(seed));
      want_mode <= PRPO_PRELOAD;
      want_pins <= v;
      ar_term <= a;
      ap_term <= p;
      repeat (6) @(posedge sys_clk);
      note({1'b0, r, 16'h0}, {9'h1ff, 8'h00, 8'hff});
      ar_term <= 8'h00;
      ap_term <= 8'h00;
      d_in <= r;
      want_mode <= PRPO_OBSERVE;
      repeat (6) @(posedge sys_clk);
      note({1'b0, r & ~cfg.comb, (r & ~cfg.comb) ^ cfg.polarity, 8'hff}, 25'h1ffffff);
      want_mode <= it[1] ? PRPO_SPARE : PRPO_NORMAL;
      comb_in <= 8'($random(seed));
      repeat (6) @(posedge sys_clk);
      note({1'b0, r, ((cfg.comb & comb_in) | (r & ~cfg.comb)) ^ cfg.polarity, cfg.oe},
        25'h1ffffff);
    end
    complete_run();
  end
endmodule : prpo_top_tb_top
